// ===== design/adcseq_map.svh
// Register map, field positions, reset values and timing counts
// Assumes a 40 MHz system clock and one AXI4-Lite word per register
//
// Contract
// - Result code is 10-bit straight binary, clamped to 000h and 3FFh.
// - Sample window opens no sooner than two clocks after a start trigger.
// - Sample window lasts 2 to 32 converter clocks, set by acquisition_prescaler.
// - Conversion phase lasts at least ten converter clock periods.
// - Result register loads no sooner than two clocks after conversion ends.
// - converter_interrupt follows the completion flag by two clocks.
// - Start delay, window, conversion and load delay together stay within 500 ns; the sequencer does not enforce this and sets the overrun status bit instead.
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH

// Register byte offsets
`define ADCSEQ_OFF_CTRL 8'h00
`define ADCSEQ_OFF_CHSEL 8'h04
`define ADCSEQ_OFF_STATUS 8'h08
`define ADCSEQ_OFF_RESULT 8'h0c

// converter_control_one fields
`define ADCSEQ_CTRL_DIV_LSB 0
`define ADCSEQ_CTRL_DIV_MSB 3
`define ADCSEQ_CTRL_ACQ_LSB 4
`define ADCSEQ_CTRL_ACQ_MSB 8
`define ADCSEQ_CTRL_PWR_BIT 9
`define ADCSEQ_CTRL_START_BIT 10
`define ADCSEQ_CTRL_RESET 10'h001

// channel_select_sequence field
`define ADCSEQ_CHSEL_LSB 0
`define ADCSEQ_CHSEL_MSB 3
`define ADCSEQ_CHSEL_RESET 4'h0

// Status fields
`define ADCSEQ_ST_BUSY_BIT 0
`define ADCSEQ_ST_DONE_BIT 1
`define ADCSEQ_ST_OVR_BIT 2
`define ADCSEQ_ST_IRQ_BIT 3

// Result range
`define ADCSEQ_CODE_MIN 10'h000
`define ADCSEQ_CODE_MAX 10'h3ff

// Timing
`define ADCSEQ_CLK_PERIOD_PS 25000
`define ADCSEQ_TAD_MIN_PS 33300
`define ADCSEQ_TAD_MIN_CYC \
   ((`ADCSEQ_TAD_MIN_PS + `ADCSEQ_CLK_PERIOD_PS - 1) / `ADCSEQ_CLK_PERIOD_PS)
`define ADCSEQ_SHC_MAX_NS 500
`define ADCSEQ_SHC_MAX_CYC \
   ((`ADCSEQ_SHC_MAX_NS * 1000) / `ADCSEQ_CLK_PERIOD_PS)
`define ADCSEQ_SOC_SH_CYC 2
`define ADCSEQ_EOC_CYC 2
`define ADCSEQ_IRQ_CYC 2
`define ADCSEQ_SH_MIN_TICKS 2
`define ADCSEQ_SH_MAX_TICKS 32
`define ADCSEQ_CONV_TICKS 10

`endif

// ===== design/adcseq_pkg.sv
// Types shared by the converter sequencer
// Assumes the map header supplies all numbers
package adcseq_pkg;

   typedef enum logic [4:0] {
      ADCSEQ_IDLE   = 5'b00001,
      ADCSEQ_SOCW   = 5'b00010,
      ADCSEQ_SAMPLE = 5'b00100,
      ADCSEQ_CONV   = 5'b01000,
      ADCSEQ_EOCW   = 5'b10000
   } adcseq_state_e;

   typedef enum logic [1:0] {
      ADCSEQ_OKAY   = 2'b00,
      ADCSEQ_SLVERR = 2'b10
   } adcseq_resp_e;

endpackage : adcseq_pkg

// ===== design/adcseq_prescaler.sv
// Converter clock tick generator
// Assumes period is at least 2 and restart is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module adcseq_prescaler #(
   parameter int W = 5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic restart,
   input wire logic [W-1:0] period,
   // Tick
   output logic tick
);
   logic [W-1:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   always_comb begin
      cnt_d = cnt_q + 1'b1;
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
      end else if (cnt_q == period - 1'b1) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : adcseq_prescaler
`default_nettype wire

// ===== design/adcseq_top.sv
// Converter sequencer with AXI4-Lite register slave
// Assumes analog core inputs and soc_trigger are asynchronous to clk
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_map.svh"
module adcseq_top #(
   parameter int ADDR_W = 8,
   parameter int CODE_W = 10,
   parameter int DIV_W = 4,
   parameter int ACQ_W = 5,
   parameter int CH_W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog core
   input wire logic soc_trigger,
   input wire logic [CODE_W-1:0] core_code,
   input wire logic core_over,
   input wire logic core_under,
   output logic sample_hold,
   output logic convert_active,
   output logic conv_tick,
   output logic analog_power,
   output logic [CH_W-1:0] analog_channel,
   output logic converter_interrupt
);
   localparam int PER_W = DIV_W + 1;
   localparam int RUN_W = 8;
   localparam logic [PER_W-1:0] TAD_MIN =
      PER_W'(`ADCSEQ_TAD_MIN_CYC);
   localparam logic [RUN_W-1:0] SHC_MAX = RUN_W'(`ADCSEQ_SHC_MAX_CYC);

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off >> 2));
   endfunction : hit

   // Input synchronisers
   logic [CODE_W+2:0] in_s1_q, in_s2_q;
   logic soc_s3_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_s1_q <= '0;
         in_s2_q <= '0;
         soc_s3_q <= 1'b0;
      end else begin
         in_s1_q <= {soc_trigger, core_over, core_under, core_code};
         in_s2_q <= in_s1_q;
         soc_s3_q <= in_s2_q[CODE_W+2];
      end
   end

   // Register write side
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [ACQ_W-1:0] acq_q, acq_d;
   logic pwr_q, pwr_d;
   logic [CH_W-1:0] chsel_q, chsel_d;
   logic sw_start, clr_done, clr_ovr;
   logic do_wr;

   always_comb begin
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      div_d = div_q;
      acq_d = acq_q;
      pwr_d = pwr_q;
      chsel_d = chsel_q;
      sw_start = 1'b0;
      clr_done = 1'b0;
      clr_ovr = 1'b0;
      if (s_axi_awvalid && !aw_have_q) begin
         awaddr_d = s_axi_awaddr;
         aw_have_d = 1'b1;
      end
      if (s_axi_wvalid && !w_have_q) begin
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
         w_have_d = 1'b1;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      do_wr = aw_have_q && w_have_q && !bvalid_q;
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = adcseq_pkg::ADCSEQ_OKAY;
         if (hit(awaddr_q, `ADCSEQ_OFF_CTRL)) begin
            if (wstrb_q[0]) begin
               div_d = wdata_q[`ADCSEQ_CTRL_DIV_MSB:`ADCSEQ_CTRL_DIV_LSB];
               acq_d[3:0] = wdata_q[7:`ADCSEQ_CTRL_ACQ_LSB];
            end
            if (wstrb_q[1]) begin
               acq_d[4] = wdata_q[`ADCSEQ_CTRL_ACQ_MSB];
               pwr_d = wdata_q[`ADCSEQ_CTRL_PWR_BIT];
               sw_start = wdata_q[`ADCSEQ_CTRL_START_BIT];
            end
         end else if (hit(awaddr_q, `ADCSEQ_OFF_CHSEL)) begin
            if (wstrb_q[0]) begin
               chsel_d = wdata_q[`ADCSEQ_CHSEL_MSB:`ADCSEQ_CHSEL_LSB];
            end
         end else if (hit(awaddr_q, `ADCSEQ_OFF_STATUS)) begin
            if (wstrb_q[0]) begin
               clr_done = wdata_q[`ADCSEQ_ST_DONE_BIT];
               clr_ovr = wdata_q[`ADCSEQ_ST_OVR_BIT];
            end
         end else if (!hit(awaddr_q, `ADCSEQ_OFF_RESULT)) begin
            bresp_d = adcseq_pkg::ADCSEQ_SLVERR;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= adcseq_pkg::ADCSEQ_OKAY;
         div_q <= DIV_W'(`ADCSEQ_CTRL_RESET);
         acq_q <= '0;
         pwr_q <= 1'b0;
         chsel_q <= CH_W'(`ADCSEQ_CHSEL_RESET);
      end else begin
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         div_q <= div_d;
         acq_q <= acq_d;
         pwr_q <= pwr_d;
         chsel_q <= chsel_d;
      end
   end

   // Prescaled converter clock
   logic [PER_W-1:0] period;
   logic ps_restart, tick;
   assign period = (PER_W'(div_q) + 1'b1 < TAD_MIN) ?
                   TAD_MIN : PER_W'(div_q) + 1'b1;

   adcseq_prescaler #(.W(PER_W)) u_prescaler (
      .clk(clk),
      .resetn(resetn),
      .restart(ps_restart),
      .period(period),
      .tick(tick)
   );

   // Conversion sequence
   adcseq_pkg::adcseq_state_e state_q, state_d;
   logic [5:0] cnt_q, cnt_d;
   logic [RUN_W-1:0] run_q, run_d;
   logic [5:0] sh_len;
   logic [CODE_W-1:0] hold_q, hold_d, result_q, result_d;
   logic done_q, done_d, ovr_q, ovr_d;
   logic [`ADCSEQ_IRQ_CYC-1:0] irq_q, irq_d;
   logic sh_q, sh_d, cv_q, cv_d;
   logic load;

   assign sh_len = 6'(acq_q) + 6'd2 > 6'(`ADCSEQ_SH_MAX_TICKS) ?
                   6'(`ADCSEQ_SH_MAX_TICKS) : 6'(acq_q) + 6'd2;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      hold_d = hold_q;
      result_d = result_q;
      done_d = done_q && !clr_done;
      ovr_d = ovr_q && !clr_ovr;
      run_d = (run_q == '1) ? run_q : run_q + 1'b1;
      ps_restart = 1'b0;
      load = 1'b0;
      case (state_q)
         adcseq_pkg::ADCSEQ_IDLE: begin
            run_d = '0;
            if (pwr_q && (sw_start || (in_s2_q[CODE_W+2] && !soc_s3_q))) begin
               state_d = adcseq_pkg::ADCSEQ_SOCW;
               cnt_d = '0;
               run_d = RUN_W'(1);
            end
         end
         adcseq_pkg::ADCSEQ_SOCW: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == 6'(`ADCSEQ_SOC_SH_CYC - 1)) begin
               state_d = adcseq_pkg::ADCSEQ_SAMPLE;
               cnt_d = '0;
               ps_restart = 1'b1;
            end
         end
         adcseq_pkg::ADCSEQ_SAMPLE: begin
            if (tick) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == sh_len - 1'b1) begin
                  state_d = adcseq_pkg::ADCSEQ_CONV;
                  cnt_d = '0;
               end
            end
         end
         adcseq_pkg::ADCSEQ_CONV: begin
            if (tick) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == 6'(`ADCSEQ_CONV_TICKS - 1)) begin
                  state_d = adcseq_pkg::ADCSEQ_EOCW;
                  cnt_d = '0;
                  if (in_s2_q[CODE_W]) begin
                     hold_d = `ADCSEQ_CODE_MIN;
                  end else if (in_s2_q[CODE_W+1]) begin
                     hold_d = `ADCSEQ_CODE_MAX;
                  end else begin
                     hold_d = in_s2_q[CODE_W-1:0];
                  end
               end
            end
         end
         adcseq_pkg::ADCSEQ_EOCW: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == 6'(`ADCSEQ_EOC_CYC - 1)) begin
               state_d = adcseq_pkg::ADCSEQ_IDLE;
               cnt_d = '0;
               load = 1'b1;
            end
         end
         default: begin
            state_d = adcseq_pkg::ADCSEQ_IDLE;
            cnt_d = '0;
         end
      endcase
      if (load) begin
         result_d = hold_q;
         done_d = 1'b1;
         if (run_q > SHC_MAX) begin
            ovr_d = 1'b1;
         end
      end
      irq_d = {irq_q[`ADCSEQ_IRQ_CYC-2:0], done_q};
      sh_d = (state_d == adcseq_pkg::ADCSEQ_SAMPLE);
      cv_d = (state_d == adcseq_pkg::ADCSEQ_CONV);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= adcseq_pkg::ADCSEQ_IDLE;
         cnt_q <= '0;
         run_q <= '0;
         hold_q <= '0;
         result_q <= '0;
         done_q <= 1'b0;
         ovr_q <= 1'b0;
         irq_q <= '0;
         sh_q <= 1'b0;
         cv_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
         hold_q <= hold_d;
         result_q <= result_d;
         done_q <= done_d;
         ovr_q <= ovr_d;
         irq_q <= irq_d;
         sh_q <= sh_d;
         cv_q <= cv_d;
      end
   end

   // Register read side
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rdata_d = '0;
         rresp_d = adcseq_pkg::ADCSEQ_OKAY;
         if (hit(s_axi_araddr, `ADCSEQ_OFF_CTRL)) begin
            rdata_d[`ADCSEQ_CTRL_DIV_MSB:`ADCSEQ_CTRL_DIV_LSB] = div_q;
            rdata_d[`ADCSEQ_CTRL_ACQ_MSB:`ADCSEQ_CTRL_ACQ_LSB] = acq_q;
            rdata_d[`ADCSEQ_CTRL_PWR_BIT] = pwr_q;
         end else if (hit(s_axi_araddr, `ADCSEQ_OFF_CHSEL)) begin
            rdata_d[`ADCSEQ_CHSEL_MSB:`ADCSEQ_CHSEL_LSB] = chsel_q;
         end else if (hit(s_axi_araddr, `ADCSEQ_OFF_STATUS)) begin
            rdata_d[`ADCSEQ_ST_BUSY_BIT] =
               (state_q != adcseq_pkg::ADCSEQ_IDLE);
            rdata_d[`ADCSEQ_ST_DONE_BIT] = done_q;
            rdata_d[`ADCSEQ_ST_OVR_BIT] = ovr_q;
            rdata_d[`ADCSEQ_ST_IRQ_BIT] = irq_q[`ADCSEQ_IRQ_CYC-1];
         end else if (hit(s_axi_araddr, `ADCSEQ_OFF_RESULT)) begin
            rdata_d[CODE_W-1:0] = result_q;
         end else begin
            rresp_d = adcseq_pkg::ADCSEQ_SLVERR;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= adcseq_pkg::ADCSEQ_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // Outputs
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign sample_hold = sh_q;
   assign convert_active = cv_q;
   assign conv_tick = tick;
   assign analog_power = pwr_q;
   assign analog_channel = chsel_q;
   assign converter_interrupt = irq_q[`ADCSEQ_IRQ_CYC-1];
endmodule : adcseq_top
`default_nettype wire

// ===== bench/adcseq_asserts.sv
// Checker for the converter sequencer top-level ports
// Assumes bind from tb; one clock domain, reset active low
`timescale 1ns/1ps
`default_nettype none
module adcseq_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Analog core
   input wire logic sample_hold,
   input wire logic convert_active,
   input wire logic conv_tick,
   input wire logic converter_interrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [9:0] sh_cyc_q, sh_cyc_d, cv_cyc_q, cv_cyc_d;
   always_comb begin
      sh_cyc_d = sample_hold ? sh_cyc_q + 10'h001 : 10'h000;
      cv_cyc_d = convert_active ? cv_cyc_q + 10'h001 : 10'h000;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sh_cyc_q <= 10'h000;
         cv_cyc_q <= 10'h000;
      end else begin
         sh_cyc_q <= sh_cyc_d;
         cv_cyc_q <= cv_cyc_d;
      end
   end
   a_window_length: assert property ($fell(sample_hold) |->
      sh_cyc_q >= 10'h004 && sh_cyc_q <= 10'h200)
      else $error("sample window length out of range");
   a_conv_length: assert property ($fell(convert_active) |->
      cv_cyc_q >= 10'h014) else $error("conversion phase too short");
   a_window_then_conv: assert property ($fell(sample_hold) |->
      convert_active) else $error("conversion did not follow window");
   a_phase_exclusive: assert property (!(sample_hold && convert_active))
      else $error("window and conversion overlap");
   a_start_quiet: assert property ($rose(sample_hold) |->
      $past(!convert_active, 1) && $past(!convert_active, 2))
      else $error("window opened too early");
   a_irq_delay: assert property ($fell(convert_active) |->
      !converter_interrupt [*3] ##[1:4] converter_interrupt)
      else $error("interrupt timing after conversion wrong");
   a_tick_spacing: assert property (conv_tick |=> !conv_tick)
      else $error("converter clock period below two cycles");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed while waiting");
   c_window: cover property ($rose(sample_hold));
   c_irq: cover property ($rose(converter_interrupt));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : adcseq_checker
`default_nettype wire

// ===== bench/adcseq_core_model.sv
// Behavioural analog core answering the sequencer
// Assumes tb sets the level; lines hold only while sampling or converting
`timescale 1ns/1ps
`default_nettype none
module adcseq_core_model (
   // Sequencer side
   input wire logic sample_hold,
   input wire logic convert_active,
   // Level chosen by the bench
   input wire logic [9:0] set_code,
   input wire logic set_over,
   input wire logic set_under,
   // Outputs to sequencer
   output logic [9:0] core_code,
   output logic core_over,
   output logic core_under
);
   logic active;
   assign active = sample_hold | convert_active;
   // Outside the phases the lines show the inverse, never the last value
   assign core_code = active ? set_code : ~set_code;
   assign core_over = active ? set_over : ~set_over;
   assign core_under = active ? set_under : ~set_under;
endmodule : adcseq_core_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the converter sequencer
// Assumes the analog core model and the checker bound below
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, soc_trigger = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [9:0] set_code = 10'h000, core_code;
   logic set_over = 1'b0, set_under = 1'b0, core_over, core_under;
   logic sample_hold, convert_active, conv_tick, analog_power, irq;
   logic [3:0] analog_channel;
   logic [33:0] exp_q[$];
   logic [1:0] expb_q[$];
   int fail_count = 0, checked = 0;
   always #12.5 clk = ~clk;
   adcseq_top i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .soc_trigger(soc_trigger), .core_code(core_code),
      .core_over(core_over), .core_under(core_under),
      .sample_hold(sample_hold), .convert_active(convert_active),
      .conv_tick(conv_tick), .analog_power(analog_power),
      .analog_channel(analog_channel), .converter_interrupt(irq));
   adcseq_core_model i_core (.sample_hold(sample_hold),
      .convert_active(convert_active), .set_code(set_code),
      .set_over(set_over), .set_under(set_under), .core_code(core_code),
      .core_over(core_over), .core_under(core_under));
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      checked++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            want);
      end
   endtask : check
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      expb_q.push_back(a > 8'h0c ? 2'b10 : 2'b00);
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] want);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      exp_q.push_back(want);
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask : rd
   // Read and write answers are compared in request order
   always @(posedge clk) begin
      if (rvalid && rready && exp_q.size() > 0)
         check({rresp, rdata}, exp_q.pop_front());
      if (bvalid && bready && expb_q.size() > 0)
         check(bresp, expb_q.pop_front());
   end
   task automatic convert(input logic [3:0] ch, input logic [4:0] acq,
      input logic [9:0] code, input logic ov, input logic un,
      input logic [9:0] want, input logic hw);
      int n;
      logic cold;
      cold = !analog_power;
      set_code <= code; set_over <= ov; set_under <= un;
      wr(8'h04, {28'h0, ch});
      wr(8'h00, {22'h0, 1'b1, acq, 4'h1});
      if (cold) repeat (400) @(posedge clk);
      wr(8'h00, {21'h0, !hw, 1'b1, acq, 4'h1});
      if (hw) begin
         soc_trigger <= 1'b1;
         repeat (3) @(posedge clk);
         soc_trigger <= 1'b0;
      end
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check(irq, 1'b1);
      check(analog_power, 1'b1);
      check(analog_channel, ch);
      rd(8'h0c, {24'h0, want});
      rd(8'h0c, {24'h0, want});
      rd(8'h08, 34'h00000000e);
      wr(8'h08, 32'h6);
      repeat (4) @(posedge clk);
      rd(8'h08, 34'h0);
   endtask : convert
   initial begin
      logic [9:0] c;
      logic [4:0] acq_tab[4];
      void'($urandom(33765));
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h00, 34'h1);
      rd(8'h04, 34'h0);
      rd(8'h08, 34'h0);
      rd(8'h0c, 34'h0);
      rd(8'h10, {2'b10, 32'h0});
      wr(8'h10, 32'hffffffff);
      rd(8'h00, 34'h1);
      wr(8'h00, 32'h400);
      repeat (60) @(posedge clk);
      rd(8'h08, 34'h0);
      $display("Test reset and refusals done");
      acq_tab = '{5'h00, 5'h1e, 5'h1f, 5'($urandom_range(0, 31))};
      for (int i = 0; i < 5; i++) begin
         c = 10'($urandom_range(0, 1023));
         convert(4'(i), acq_tab[i % 4], c, 1'b0, 1'b0, c, i == 4);
      end
      $display("Test channels and windows done");
      convert(4'h2, 5'h03, 10'h155, 1'b1, 1'b0, 10'h3ff, 1'b0);
      convert(4'h3, 5'h03, 10'h2aa, 1'b0, 1'b1, 10'h000, 1'b0);
      convert(4'h4, 5'h03, 10'h0f0, 1'b1, 1'b1, 10'h000, 1'b0);
      set_code <= 10'h123;
      repeat (10) @(posedge clk);
      rd(8'h0c, 34'h0);
      $display("Test clamping and hold done");
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule : tb
bind adcseq_top adcseq_checker i_chk (.clk(clk), .resetn(resetn),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .sample_hold(sample_hold),
   .convert_active(convert_active), .conv_tick(conv_tick),
   .converter_interrupt(converter_interrupt));
`default_nettype wire
